// ==== icf_ctrl.sv ====
// module: interrupt control, flag, edge and priority logic
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
module icf_ctrl
#(
    parameter logic HAS_PSP = 1'b1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire icf_pkg::icf_bus_t bus,
    output logic [7:0] rdata,
    // peripheral events
    input wire icf_pkg::icf_events_t ev,
    input wire icf_pkg::icf_ccp_mode_t ccp_mode,
    // pins
    input wire logic [3:0] ext_line_pin,
    input wire logic [3:0] port_change_pin_group,
    output logic [7:0] port_pullup_en,
    // processor core
    input wire logic irq_ack,
    output logic irq_high,
    output logic irq_low,
    output logic [15:0] irq_vector,
    output logic serial_one_rx_read,
    output logic serial_one_tx_write
);

    icf_pkg::icf_state_t s_r;
    icf_pkg::icf_state_t s_nxt;

    logic prio_mode;
    logic [3:0] ext_rise;
    logic [3:0] ext_fall;
    logic [3:0] ext_hit;
    logic [7:0] main_set;
    logic [7:0] xl_set;
    logic [7:0] pf_set;
    logic wr_main;
    logic wr_xl;
    logic wr_pf;
    logic [7:0] pf_act;
    logic [7:0] pf_hi;
    logic [7:0] pf_lo;
    logic core_hi_req;
    logic core_lo_req;
    logic periph_req_hi;
    logic periph_req_lo;
    logic req_any_compat;
    logic req_hi;
    logic req_lo;
    logic take_hi;
    logic take_lo;

    function automatic logic is_wr(input icf_pkg::icf_bus_t b,
                                   input logic [3:0] ofs);
        is_wr = b.wr && (b.addr == ofs);
    endfunction : is_wr

    function automatic logic is_rd(input icf_pkg::icf_bus_t b,
                                   input logic [3:0] ofs);
        is_rd = b.rd && (b.addr == ofs);
    endfunction : is_rd

    // sticky flag: the hardware set wins over a clear in the same cycle
    function automatic logic [7:0] sticky(input logic [7:0] cur,
                                          input logic [7:0] set,
                                          input logic wr,
                                          input logic [7:0] wd);
        sticky = (wr ? wd : cur) | set;
    endfunction : sticky

    // -----------------------------------------------------------------------
    // event decode
    // -----------------------------------------------------------------------
    assign prio_mode = s_r.reset_control[icf_pkg::RC_PRIO_MODE];

    assign ext_rise = s_r.ext_sync2 & ~s_r.ext_prev;
    assign ext_fall = ~s_r.ext_sync2 & s_r.ext_prev;

    always_comb
    begin
        ext_hit[0] = s_r.edge_prio[icf_pkg::EP_EDGE_X0] ? ext_rise[0]
                                                        : ext_fall[0];
        ext_hit[1] = s_r.edge_prio[icf_pkg::EP_EDGE_X1] ? ext_rise[1]
                                                        : ext_fall[1];
        ext_hit[2] = s_r.edge_prio[icf_pkg::EP_EDGE_X2] ? ext_rise[2]
                                                        : ext_fall[2];
        ext_hit[3] = s_r.edge_prio[icf_pkg::EP_EDGE_X3] ? ext_rise[3]
                                                        : ext_fall[3];
    end

    always_comb
    begin
        main_set = 8'h00;
        main_set[icf_pkg::MAIN_T0_FLAG] = ev.timer_zero_overflow;
        main_set[icf_pkg::MAIN_X0_FLAG] = ext_hit[0];
        // mismatch against the last port read keeps setting the flag
        main_set[icf_pkg::MAIN_PC_FLAG] =
            |(s_r.pc_sync2 ^ s_r.pc_snap);
        xl_set = 8'h00;
        xl_set[icf_pkg::XL_X3_FLAG] = ext_hit[3];
        xl_set[icf_pkg::XL_X2_FLAG] = ext_hit[2];
        xl_set[icf_pkg::XL_X1_FLAG] = ext_hit[1];
        pf_set = {ev.psp_access & HAS_PSP,
                  ev.conversion_done,
                  2'b00,
                  ev.sync_serial_one_done,
                  (ev.ccp_capture &&
                   ccp_mode == icf_pkg::CCP_CAPTURE) ||
                  (ev.ccp_compare &&
                   ccp_mode == icf_pkg::CCP_COMPARE),
                  ev.timer_two_period_match,
                  ev.timer_one_overflow};
    end

    assign wr_main = is_wr(bus, icf_pkg::OFS_MAIN);
    assign wr_xl = is_wr(bus, icf_pkg::OFS_EXT_LINES);
    assign wr_pf = is_wr(bus, icf_pkg::OFS_PERIPH_ONE);

    // -----------------------------------------------------------------------
    // request routing
    // -----------------------------------------------------------------------
    assign pf_act = s_r.periph & s_r.periph_en;
    assign pf_hi = pf_act & s_r.periph_prio;
    assign pf_lo = pf_act & ~s_r.periph_prio;

    always_comb
    begin
        core_hi_req = 1'b0;
        core_lo_req = 1'b0;
        // timer zero, line zero (always high), port change, lines 1..3
        if (s_r.main[icf_pkg::MAIN_T0_FLAG] && s_r.main[icf_pkg::MAIN_T0_EN])
        begin
            core_hi_req |= s_r.edge_prio[icf_pkg::EP_T0_PRIO];
            core_lo_req |= !s_r.edge_prio[icf_pkg::EP_T0_PRIO];
        end
        if (s_r.main[icf_pkg::MAIN_X0_FLAG] && s_r.main[icf_pkg::MAIN_X0_EN])
        begin
            core_hi_req = 1'b1;
        end
        if (s_r.main[icf_pkg::MAIN_PC_FLAG] && s_r.main[icf_pkg::MAIN_PC_EN])
        begin
            core_hi_req |= s_r.edge_prio[icf_pkg::EP_PC_PRIO];
            core_lo_req |= !s_r.edge_prio[icf_pkg::EP_PC_PRIO];
        end
        if (s_r.ext_lines[icf_pkg::XL_X1_FLAG] &&
            s_r.ext_lines[icf_pkg::XL_X1_EN])
        begin
            core_hi_req |= s_r.ext_lines[icf_pkg::XL_X1_PRIO];
            core_lo_req |= !s_r.ext_lines[icf_pkg::XL_X1_PRIO];
        end
        if (s_r.ext_lines[icf_pkg::XL_X2_FLAG] &&
            s_r.ext_lines[icf_pkg::XL_X2_EN])
        begin
            core_hi_req |= s_r.ext_lines[icf_pkg::XL_X2_PRIO];
            core_lo_req |= !s_r.ext_lines[icf_pkg::XL_X2_PRIO];
        end
        if (s_r.ext_lines[icf_pkg::XL_X3_FLAG] &&
            s_r.ext_lines[icf_pkg::XL_X3_EN])
        begin
            core_hi_req |= s_r.edge_prio[icf_pkg::EP_X3_PRIO];
            core_lo_req |= !s_r.edge_prio[icf_pkg::EP_X3_PRIO];
        end
    end

    assign periph_req_hi = |pf_hi;
    assign periph_req_lo = |pf_lo;
    assign req_any_compat = core_hi_req || core_lo_req ||
        ((periph_req_hi || periph_req_lo) &&
         s_r.main[icf_pkg::MAIN_PERIPH]);

    always_comb
    begin
        if (prio_mode)
        begin
            // bit 6 only opens low level while bit 7 is set
            req_hi = s_r.main[icf_pkg::MAIN_GLOBAL] &&
                     (core_hi_req || periph_req_hi);
            req_lo = s_r.main[icf_pkg::MAIN_GLOBAL] &&
                     s_r.main[icf_pkg::MAIN_PERIPH] &&
                     (core_lo_req || periph_req_lo);
        end
        else
        begin
            // priority bits ignored, all go out high
            req_hi = s_r.main[icf_pkg::MAIN_GLOBAL] && req_any_compat;
            req_lo = 1'b0;
        end
    end

    // high take wins when both levels are pending
    assign take_hi = irq_ack && s_r.irq_high;
    assign take_lo = irq_ack && !s_r.irq_high && s_r.irq_low;

    // -----------------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ext_sync1 = ext_line_pin;
        s_nxt.ext_sync2 = s_r.ext_sync1;
        s_nxt.ext_prev = s_r.ext_sync2;
        s_nxt.pc_sync1 = port_change_pin_group;
        s_nxt.pc_sync2 = s_r.pc_sync1;

        s_nxt.main = sticky(s_r.main, main_set, wr_main, bus.wdata);
        s_nxt.ext_lines = sticky(s_r.ext_lines, xl_set, wr_xl, bus.wdata);
        s_nxt.periph = sticky(s_r.periph, pf_set, wr_pf,
                              (bus.wdata & icf_pkg::PF_SW_MASK) |
                              (s_r.periph & ~icf_pkg::PF_SW_MASK));
        // buffer-status flags track the serial port levels
        s_nxt.periph[icf_pkg::PF_RX_FULL] = ev.serial_one_rx_full;
        s_nxt.periph[icf_pkg::PF_TX_EMPTY] = ev.serial_one_tx_empty;

        if (is_wr(bus, icf_pkg::OFS_EDGE_PRIO))
        begin
            s_nxt.edge_prio = bus.wdata;
        end
        if (is_wr(bus, icf_pkg::OFS_PERIPH_EN_ONE))
        begin
            s_nxt.periph_en = bus.wdata;
        end
        if (is_wr(bus, icf_pkg::OFS_PERIPH_PRIO_ONE))
        begin
            s_nxt.periph_prio = bus.wdata;
        end
        if (is_wr(bus, icf_pkg::OFS_RESET_CONTROL))
        begin
            s_nxt.reset_control = bus.wdata;
        end
        if (is_wr(bus, icf_pkg::OFS_PORT_LATCH))
        begin
            s_nxt.port_latch = bus.wdata;
        end
        // snapshot is the last port read; a pin that differs from it
        // keeps the change flag up even against a software clear
        if (is_rd(bus, icf_pkg::OFS_PORT_READ))
        begin
            s_nxt.pc_snap = s_r.pc_sync2;
        end

        // acknowledge clears the gate of the taken level
        if (take_hi)
        begin
            s_nxt.main[icf_pkg::MAIN_GLOBAL] = 1'b0;
        end
        else if (take_lo)
        begin
            s_nxt.main[icf_pkg::MAIN_PERIPH] = 1'b0;
        end

        s_nxt.irq_high = req_hi && !take_hi;
        s_nxt.irq_low = req_lo && !take_lo && !take_hi;
        s_nxt.vector = req_hi ? icf_pkg::VEC_HIGH
                     : req_lo ? icf_pkg::VEC_LOW
                     : icf_pkg::VEC_HIGH;

        unique case (bus.addr)
            icf_pkg::OFS_MAIN: s_nxt.rdata = s_r.main;
            icf_pkg::OFS_EDGE_PRIO: s_nxt.rdata = s_r.edge_prio;
            icf_pkg::OFS_EXT_LINES: s_nxt.rdata = s_r.ext_lines;
            icf_pkg::OFS_PERIPH_ONE: s_nxt.rdata = s_r.periph;
            icf_pkg::OFS_PERIPH_EN_ONE: s_nxt.rdata = s_r.periph_en;
            icf_pkg::OFS_PERIPH_PRIO_ONE: s_nxt.rdata = s_r.periph_prio;
            icf_pkg::OFS_RESET_CONTROL: s_nxt.rdata = s_r.reset_control;
            icf_pkg::OFS_PORT_LATCH: s_nxt.rdata = s_r.port_latch;
            icf_pkg::OFS_PORT_READ: s_nxt.rdata = {4'h0, s_r.pc_sync2};
            default: s_nxt.rdata = 8'h00;
        endcase
        if (!bus.rd)
        begin
            s_nxt.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.main <= icf_pkg::RST_MAIN;
            s_r.edge_prio <= icf_pkg::RST_EDGE_PRIO;
            s_r.ext_lines <= icf_pkg::RST_EXT_LINES;
            s_r.periph <= icf_pkg::RST_PERIPH;
            s_r.periph_en <= icf_pkg::RST_PERIPH;
            s_r.periph_prio <= icf_pkg::RST_PERIPH_PRIO;
            s_r.reset_control <= icf_pkg::RST_RESET_CONTROL;
            s_r.port_latch <= icf_pkg::RST_PORT_LATCH;
            s_r.vector <= icf_pkg::VEC_HIGH;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // -----------------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------------
    assign rdata = s_r.rdata;
    assign irq_high = s_r.irq_high;
    assign irq_low = s_r.irq_low;
    assign irq_vector = s_r.vector;
    assign port_pullup_en = s_r.edge_prio[icf_pkg::EP_PULLUP_DIS] ? 8'h00
                                                                : s_r.port_latch;
    // read/write of the serial buffers are handled by the serial port
    assign serial_one_rx_read = 1'b0;
    assign serial_one_tx_write = 1'b0;

endmodule : icf_ctrl

// ==== icf_pkg.sv ====
// package: register map, field positions and types of the interrupt flag block
package icf_pkg;

    // register offsets (byte index on the plain register port)
    localparam logic [3:0] OFS_MAIN = 4'h0;
    localparam logic [3:0] OFS_EDGE_PRIO = 4'h1;
    localparam logic [3:0] OFS_EXT_LINES = 4'h2;
    localparam logic [3:0] OFS_PERIPH_ONE = 4'h3;
    localparam logic [3:0] OFS_PERIPH_EN_ONE = 4'h4;
    localparam logic [3:0] OFS_PERIPH_PRIO_ONE = 4'h5;
    localparam logic [3:0] OFS_RESET_CONTROL = 4'h6;
    localparam logic [3:0] OFS_PORT_LATCH = 4'h7;
    localparam logic [3:0] OFS_PORT_READ = 4'h8;

    // main control fields
    localparam int MAIN_GLOBAL = 7;
    localparam int MAIN_PERIPH = 6;
    localparam int MAIN_T0_EN = 5;
    localparam int MAIN_X0_EN = 4;
    localparam int MAIN_PC_EN = 3;
    localparam int MAIN_T0_FLAG = 2;
    localparam int MAIN_X0_FLAG = 1;
    localparam int MAIN_PC_FLAG = 0;

    // edge/priority fields
    localparam int EP_PULLUP_DIS = 7;
    localparam int EP_EDGE_X0 = 6;
    localparam int EP_EDGE_X1 = 5;
    localparam int EP_EDGE_X2 = 4;
    localparam int EP_EDGE_X3 = 3;
    localparam int EP_T0_PRIO = 2;
    localparam int EP_X3_PRIO = 1;
    localparam int EP_PC_PRIO = 0;

    // external line register fields
    localparam int XL_X2_PRIO = 7;
    localparam int XL_X1_PRIO = 6;
    localparam int XL_X3_EN = 5;
    localparam int XL_X2_EN = 4;
    localparam int XL_X1_EN = 3;
    localparam int XL_X3_FLAG = 2;
    localparam int XL_X2_FLAG = 1;
    localparam int XL_X1_FLAG = 0;

    // peripheral flag fields and the reset-control priority mode bit
    localparam int PF_PSP = 7;
    localparam int PF_RX_FULL = 5;
    localparam int PF_TX_EMPTY = 4;
    localparam int PF_CCP = 2;
    localparam int RC_PRIO_MODE = 7;

    // software-writable flags of peripheral register one
    localparam logic [7:0] PF_SW_MASK = 8'hcf;

    // reset values
    localparam logic [7:0] RST_MAIN = 8'h00;
    localparam logic [7:0] RST_EDGE_PRIO = 8'hff;
    localparam logic [7:0] RST_EXT_LINES = 8'hc0;
    localparam logic [7:0] RST_PERIPH = 8'h00;
    localparam logic [7:0] RST_PERIPH_PRIO = 8'hff;
    localparam logic [7:0] RST_RESET_CONTROL = 8'h00;
    localparam logic [7:0] RST_PORT_LATCH = 8'h00;

    // vectors
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW = 16'h0018;

    // capture/compare module mode
    typedef enum logic [1:0]
    {
        CCP_OFF,
        CCP_CAPTURE,
        CCP_COMPARE,
        CCP_PWM
    } icf_ccp_mode_t;

    // register bus request
    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } icf_bus_t;

    // one-cycle peripheral events, except the serial buffer full/empty levels
    typedef struct packed
    {
        logic timer_zero_overflow;
        logic psp_access;
        logic conversion_done;
        logic serial_one_rx_full;
        logic serial_one_tx_empty;
        logic sync_serial_one_done;
        logic ccp_capture;
        logic ccp_compare;
        logic timer_two_period_match;
        logic timer_one_overflow;
    } icf_events_t;

    // whole block state
    typedef struct packed
    {
        logic [7:0] main;
        logic [7:0] edge_prio;
        logic [7:0] ext_lines;
        logic [7:0] periph;
        logic [7:0] periph_en;
        logic [7:0] periph_prio;
        logic [7:0] reset_control;
        logic [7:0] port_latch;
        logic [3:0] ext_sync1;
        logic [3:0] ext_sync2;
        logic [3:0] ext_prev;
        logic [3:0] pc_sync1;
        logic [3:0] pc_sync2;
        logic [3:0] pc_snap;
        logic [7:0] rdata;
        logic irq_high;
        logic irq_low;
        logic [15:0] vector;
    } icf_state_t;

endpackage : icf_pkg

// ==== icf_ctrl_checker.sv ====
// checker: port-level assertions for the interrupt flag block
`timescale 1ns/100ps
module icf_ctrl_checker
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire icf_pkg::icf_bus_t bus,
    input wire logic [7:0] rdata,
    // pins and core
    input wire logic [7:0] port_pullup_en,
    input wire logic irq_ack,
    input wire logic irq_high,
    input wire logic irq_low,
    input wire logic [15:0] irq_vector,
    input wire logic serial_one_rx_read,
    input wire logic serial_one_tx_write
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // helper: a taken high request blocks all until software writes again
    // ------------------------------------------------------------------
    logic blk_r;
    logic [1:0] blk_cnt_r;
    always_ff @(posedge clk)
    begin
        if (rst || bus.wr)
        begin
            blk_r <= 1'b0;
            blk_cnt_r <= 2'h0;
        end
        else if (irq_ack && irq_high)
        begin
            blk_r <= 1'b1;
            blk_cnt_r <= 2'h0;
        end
        else if (blk_r && blk_cnt_r != 2'h3)
            blk_cnt_r <= blk_cnt_r + 2'h1;
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_pullup_cause;
        $changed(port_pullup_en) |-> $past(bus.wr);
    endproperty
    a_pullup_cause: assert property (p_pullup_cause)
        else $error("pull-up enables changed without a write");
    property p_vec_high;
        irq_high |-> irq_vector == 16'h0008;
    endproperty
    a_vec_high: assert property (p_vec_high)
        else $error("high request with wrong vector");
    property p_vec_low;
        irq_low && !irq_high |-> irq_vector == 16'h0018;
    endproperty
    a_vec_low: assert property (p_vec_low)
        else $error("low request with wrong vector");
    property p_ack_high;
        irq_ack && irq_high |-> ##[1:3] !irq_high;
    endproperty
    a_ack_high: assert property (p_ack_high)
        else $error("high request kept after take");
    property p_ack_low;
        irq_ack && irq_low && !irq_high |-> ##[1:3] !irq_low;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("low request kept after take");
    property p_blocked;
        blk_cnt_r == 2'h3 |-> !irq_high && !irq_low;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("request while global enable is cleared");
    property p_rd_unmapped;
        $past(bus.rd) && $past(bus.addr) > 4'h8 |-> rdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");
    property p_rd_idle;
        !$past(bus.rd) |-> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
    property p_serial_ties;
        !serial_one_rx_read && !serial_one_tx_write;
    endproperty
    a_serial_ties: assert property (p_serial_ties)
        else $error("serial strobes not idle");

    c_high: cover property (irq_high);
    c_low: cover property (irq_low && !irq_high);
    c_take: cover property (irq_ack && irq_high);
    c_pullup: cover property ($changed(port_pullup_en));
endmodule : icf_ctrl_checker

bind icf_ctrl icf_ctrl_checker u_chk
(
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .port_pullup_en(port_pullup_en),
    .irq_ack(irq_ack),
    .irq_high(irq_high),
    .irq_low(irq_low),
    .irq_vector(irq_vector),
    .serial_one_rx_read(serial_one_rx_read),
    .serial_one_tx_write(serial_one_tx_write)
);

// ==== icf_core_model.sv ====
// partner: processor core that takes pending requests after a delay
`timescale 1ns/100ps
module icf_core_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench control
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    // request lines
    input wire logic irq_high,
    input wire logic irq_low,
    output logic irq_ack
);
    logic [3:0] wait_r;
    logic done_r;
    // one take per request; waits for the request to drop
    always_ff @(posedge clk)
    begin
        irq_ack <= 1'b0;
        if (rst || !(irq_high || irq_low))
        begin
            wait_r <= 4'h0;
            done_r <= 1'b0;
        end
        else if (ack_en && !done_r)
        begin
            if (wait_r == ack_delay)
            begin
                irq_ack <= 1'b1;
                done_r <= 1'b1;
            end
            else
                wait_r <= wait_r + 4'h1;
        end
    end
endmodule : icf_core_model

// ==== testbench.sv ====
// testbench: directed scenarios for the interrupt flag block
`timescale 1ns/100ps
module testbench;
    logic clk;
    logic rst;
    icf_pkg::icf_bus_t bus;
    icf_pkg::icf_events_t ev;
    icf_pkg::icf_ccp_mode_t ccp_mode;
    logic [3:0] ext_line_pin;
    logic [3:0] port_change_pin_group;
    logic ack_en;
    logic [3:0] ack_delay;
    logic [7:0] rdata;
    logic [7:0] port_pullup_en;
    logic irq_ack;
    logic irq_high;
    logic irq_low;
    logic [15:0] irq_vector;
    logic rx_read;
    logic tx_write;
    int bad_count = 0;
    int n_compared = 0;
    logic [9:0] pev [5] = '{10'h100, 10'h080, 10'h010, 10'h002, 10'h001};
    logic [7:0] pmask [5] = '{8'h80, 8'h40, 8'h08, 8'h02, 8'h01};

    icf_ctrl u_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .ev(ev), .ccp_mode(ccp_mode), .ext_line_pin(ext_line_pin),
        .port_change_pin_group(port_change_pin_group),
        .port_pullup_en(port_pullup_en), .irq_ack(irq_ack),
        .irq_high(irq_high), .irq_low(irq_low), .irq_vector(irq_vector),
        .serial_one_rx_read(rx_read), .serial_one_tx_write(tx_write));
    icf_core_model u_core (.clk(clk), .rst(rst), .ack_en(ack_en),
        .ack_delay(ack_delay), .irq_high(irq_high), .irq_low(irq_low),
        .irq_ack(irq_ack));

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk8(input string what, input logic [7:0] e,
                        input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk8
    task automatic chk16(input string what, input logic [15:0] e,
                         input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk16
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd
    task automatic rdchk(input string what, input logic [3:0] a,
                         input logic [7:0] e, input logic [7:0] m);
        logic [7:0] v;
        rd(a, v);
        chk8(what, e, v & m);
    endtask : rdchk
    task automatic pulse(input logic [9:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 10'h000;
    endtask : pulse
    task automatic irqchk(input logic eh, input logic el);
        repeat (3) @(posedge clk);
        #1;
        chk8("irq", {6'h00, eh, el}, {6'h00, irq_high, irq_low});
    endtask : irqchk
    task automatic pin_chk(input int i, input logic lvl, input logic e);
        logic [7:0] v;
        logic [3:0] a;
        a = (i == 0) ? 4'h0 : 4'h2;
        @(posedge clk);
        ext_line_pin[i] <= lvl;
        repeat (4) @(posedge clk);
        rd(a, v);
        chk8("line flag", {7'h00, e}, {7'h00, v[(i == 0) ? 1 : i - 1]});
        wr(a, (i == 0) ? 8'h00 : 8'hc0);
    endtask : pin_chk

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rdchk("main", 4'h0, 8'h00, 8'hfe);
        rdchk("edge_prio", 4'h1, 8'hff, 8'hff);
        rdchk("ext_lines", 4'h2, 8'hc0, 8'hff);
        rdchk("periph", 4'h3, 8'h00, 8'hff);
        rdchk("reset_ctl", 4'h6, 8'h00, 8'hff);
        rdchk("unmapped", 4'hf, 8'h00, 8'hff);
        $display("test reset done");
    endtask : t_reset
    task automatic t_flags;
        pulse(10'h200);
        repeat (5) @(posedge clk);
        rdchk("t0 flag", 4'h0, 8'h04, 8'hff);
        wr(4'h0, 8'h00);
        rdchk("t0 clear", 4'h0, 8'h00, 8'hff);
        for (int k = 0; k < 5; k++)
        begin
            pulse(pev[k]);
            rdchk("pf", 4'h3, pmask[k], 8'hff);
            wr(4'h3, 8'h00);
            rdchk("pclear", 4'h3, 8'h00, 8'hff);
        end
        for (int m = 0; m < 4; m++)
        begin
            ccp_mode <= icf_pkg::icf_ccp_mode_t'(m);
            pulse(10'h008);
            rdchk("capture", 4'h3, (m == 1) ? 8'h04 : 8'h00, 8'hff);
            wr(4'h3, 8'h00);
            pulse(10'h004);
            rdchk("compare", 4'h3, (m == 2) ? 8'h04 : 8'h00, 8'hff);
            wr(4'h3, 8'h00);
        end
        $display("test flags done");
    endtask : t_flags
    task automatic t_levels;
        @(posedge clk);
        ev <= 10'h060;
        rdchk("levels", 4'h3, 8'h30, 8'hff);
        wr(4'h3, 8'h00);
        rdchk("levels kept", 4'h3, 8'h30, 8'hff);
        @(posedge clk);
        ev <= 10'h000;
        wr(4'h3, 8'h30);
        rdchk("levels gone", 4'h3, 8'h00, 8'hff);
        $display("test levels done");
    endtask : t_levels
    task automatic t_edges;
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h1, 8'hff);
            pin_chk(i, 1'b1, 1'b1);
            pin_chk(i, 1'b0, 1'b0);
            wr(4'h1, 8'hff ^ (8'h40 >> i));
            pin_chk(i, 1'b1, 1'b0);
            pin_chk(i, 1'b0, 1'b1);
        end
        wr(4'h1, 8'hff);
        $display("test edges done");
    endtask : t_edges
    task automatic t_port;
        @(posedge clk);
        port_change_pin_group <= 4'h9;
        repeat (4) @(posedge clk);
        rdchk("change flag", 4'h0, 8'h01, 8'hff);
        wr(4'h0, 8'h00);
        rdchk("mismatch", 4'h0, 8'h01, 8'hff);
        rdchk("port read", 4'h8, 8'h09, 8'hff);
        wr(4'h0, 8'h00);
        rdchk("change clear", 4'h0, 8'h00, 8'hff);
        $display("test port done");
    endtask : t_port
    task automatic t_pullup;
        wr(4'h7, 8'ha5);
        #1;
        chk8("pullup off", 8'h00, port_pullup_en);
        wr(4'h1, 8'h7f);
        #1;
        chk8("pullup latch", 8'ha5, port_pullup_en);
        wr(4'h1, 8'hff);
        #1;
        chk8("pullup off", 8'h00, port_pullup_en);
        $display("test pullup done");
    endtask : t_pullup
    task automatic t_compat;
        wr(4'h0, 8'h24);
        irqchk(1'b0, 1'b0);
        wr(4'h0, 8'ha4);
        irqchk(1'b1, 1'b0);
        chk16("vector", 16'h0008, irq_vector);
        ack_en <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk("taken", 4'h0, 8'h24, 8'hff);
        ack_en <= 1'b0;
        wr(4'h0, 8'h00);
        wr(4'h4, 8'h01);
        pulse(10'h001);
        wr(4'h0, 8'h80);
        irqchk(1'b0, 1'b0);
        wr(4'h0, 8'hc0);
        irqchk(1'b1, 1'b0);
        wr(4'h0, 8'h00);
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h00);
        $display("test compat done");
    endtask : t_compat
    task automatic t_prio;
        wr(4'h6, 8'h80);
        wr(4'h1, 8'hfb);
        wr(4'h0, 8'h64);
        irqchk(1'b0, 1'b0);
        wr(4'h0, 8'he4);
        irqchk(1'b0, 1'b1);
        chk16("vector", 16'h0018, irq_vector);
        ack_en <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk("low taken", 4'h0, 8'ha4, 8'hff);
        ack_en <= 1'b0;
        wr(4'h1, 8'hff);
        irqchk(1'b1, 1'b0);
        chk16("vector", 16'h0008, irq_vector);
        wr(4'h0, 8'h00);
        wr(4'h6, 8'h00);
        $display("test prio done");
    endtask : t_prio

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        #100000;
        bad_count++;
        give_verdict;
    end

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        bus = '0;
        ev = 10'h000;
        ccp_mode = icf_pkg::CCP_OFF;
        ext_line_pin = 4'h0;
        port_change_pin_group = 4'h0;
        ack_en = 1'b0;
        ack_delay = 4'h2;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_flags;
        t_levels;
        t_edges;
        t_port;
        t_pullup;
        t_compat;
        t_prio;
        give_verdict;
    end
endmodule : testbench
